/* hdl/rtdc_top.sv */
// rtdc_top: pc-style serial port whose dtr bit gates an rs485 driver
// assumes a synchronous i/o port strobe per access, serial_in synchronous
`default_nettype none
`include "rtdc_consts.svh"

module rtdc_top #(
   parameter int CLKS_PER_BIT = `RTDC_CLKS_PER_BIT
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire rtdc_pkg::rtdc_addr_t io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire rtdc_pkg::rtdc_byte_t io_wdata,
   output rtdc_pkg::rtdc_byte_t io_rdata,
   output logic serial_out,
   input wire logic serial_in,
   output logic line_driver_enable,
   output logic dtr
);
   import rtdc_pkg::*;

   function automatic logic hit(input rtdc_addr_t a, input rtdc_addr_t ofs);
      hit = (a == ofs);
   endfunction : hit

   logic rst_meta_n;
   logic rst_sync_n;
   rtdc_byte_t modem_control;
   rtdc_byte_t holding;
   logic holding_full;
   rtdc_byte_t rx_buffer;
   logic rx_ready;
   logic rx_overrun;
   rtdc_byte_t line_status;
   rtdc_rx_e rx_state;
   rtdc_byte_t rx_shift;
   logic [2:0] rx_bit;
   logic [15:0] rx_cnt;
   logic rx_done;
   logic wr_data;
   logic rd_data;

   rtdc_tx_if tx ();

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   assign wr_data = io_wr && hit(io_addr, `RTDC_OFS_DATA);
   assign rd_data = io_rd && hit(io_addr, `RTDC_OFS_DATA);

   // ------------------------------------------------------------------
   // modem control
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         modem_control <= `RTDC_MCR_RESET;
      end else if (io_wr && hit(io_addr, `RTDC_OFS_MODEM_CTRL)) begin
         modem_control <= io_wdata;
      end
   end

   assign dtr = modem_control[`RTDC_MCR_DRV_EN_BIT];
   assign line_driver_enable = modem_control[`RTDC_MCR_DRV_EN_BIT];

   // ------------------------------------------------------------------
   // transmit holding register
   // ------------------------------------------------------------------
   assign tx.load = holding_full && !tx.busy;
   assign tx.data = holding;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         holding <= `RTDC_BYTE_RESET;
         holding_full <= 1'b0;
      end else if (wr_data) begin
         // write while full overwrites the waiting byte
         holding <= io_wdata;
         holding_full <= 1'b1;
      end else if (tx.load) begin
         holding_full <= 1'b0;
      end
   end

   rtdc_tx_shift #(
      .CLKS_PER_BIT(CLKS_PER_BIT)
   ) u_tx_shift (
      .core_clk(core_clk),
      .rst_sync_n(rst_sync_n),
      .tx(tx),
      .serial_out(serial_out)
   );

   // ------------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------------
   // plain receive path
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_state <= RTDC_RX_IDLE;
         rx_shift <= `RTDC_BYTE_RESET;
         rx_bit <= 3'h0;
         rx_cnt <= 16'h0000;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         unique case (rx_state)
            RTDC_RX_IDLE: begin
               if (!serial_in) begin
                  rx_state <= RTDC_RX_START;
                  rx_cnt <= 16'(CLKS_PER_BIT / 2 - 1);
               end
            end
            RTDC_RX_START: begin
               if (rx_cnt != 16'h0000) begin
                  rx_cnt <= rx_cnt - 16'h0001;
               end else if (serial_in) begin
                  rx_state <= RTDC_RX_IDLE;
               end else begin
                  rx_state <= RTDC_RX_BITS;
                  rx_bit <= 3'h0;
                  rx_cnt <= 16'(CLKS_PER_BIT - 1);
               end
            end
            RTDC_RX_BITS: begin
               if (rx_cnt != 16'h0000) begin
                  rx_cnt <= rx_cnt - 16'h0001;
               end else begin
                  rx_shift <= {serial_in, rx_shift[7:1]};
                  rx_cnt <= 16'(CLKS_PER_BIT - 1);
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7) begin
                     rx_state <= RTDC_RX_STOP;
                  end
               end
            end
            RTDC_RX_STOP: begin
               if (rx_cnt != 16'h0000) begin
                  rx_cnt <= rx_cnt - 16'h0001;
               end else begin
                  rx_state <= RTDC_RX_IDLE;
                  rx_done <= serial_in;
               end
            end
         endcase
      end
   end

   // received byte, ready and overrun; a new byte wins over a read
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_buffer <= `RTDC_BYTE_RESET;
         rx_ready <= 1'b0;
         rx_overrun <= 1'b0;
      end else if (rx_done) begin
         rx_buffer <= rx_shift;
         rx_ready <= 1'b1;
         rx_overrun <= rx_overrun || (rx_ready && !rd_data);
      end else if (io_rd && hit(io_addr, `RTDC_OFS_LINE_STATUS)) begin
         rx_overrun <= 1'b0;
      end else if (rd_data) begin
         rx_ready <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // line status and read port
   // ------------------------------------------------------------------
   always_comb begin
      line_status = `RTDC_BYTE_RESET;
      line_status[`RTDC_LSR_RX_READY_BIT] = rx_ready;
      line_status[`RTDC_LSR_RX_OVERRUN_BIT] = rx_overrun;
      line_status[`RTDC_LSR_TX_HOLDING_BIT] = holding_full;
      line_status[`RTDC_LSR_TX_SHIFTER_BIT] = tx.busy;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         io_rdata <= `RTDC_BYTE_RESET;
      end else if (io_rd) begin
         if (hit(io_addr, `RTDC_OFS_DATA)) begin
            io_rdata <= rx_buffer;
         end else if (hit(io_addr, `RTDC_OFS_MODEM_CTRL)) begin
            io_rdata <= modem_control;
         end else if (hit(io_addr, `RTDC_OFS_LINE_STATUS)) begin
            io_rdata <= line_status;
         end else begin
            io_rdata <= `RTDC_BYTE_RESET;
         end
      end
   end
endmodule : rtdc_top

`default_nettype wire

/* hdl/rtdc_consts.svh */
// rtdc_consts.svh: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from rtdc_top, rtdc_tx_shift and rtdc_top_assertions
`ifndef RTDC_CONSTS_SVH
`define RTDC_CONSTS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define RTDC_OFS_DATA 3'h0
`define RTDC_OFS_MODEM_CTRL 3'h4
`define RTDC_OFS_LINE_STATUS 3'h5

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define RTDC_MCR_DRV_EN_BIT 0
`define RTDC_LSR_RX_READY_BIT 0
`define RTDC_LSR_RX_OVERRUN_BIT 1
`define RTDC_LSR_TX_HOLDING_BIT 5
`define RTDC_LSR_TX_SHIFTER_BIT 6

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define RTDC_MCR_RESET 8'h00
`define RTDC_BYTE_RESET 8'h00

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define RTDC_CLK_HZ 100000000
`define RTDC_BAUD_HZ 9600
`define RTDC_CLKS_PER_BIT (`RTDC_CLK_HZ / `RTDC_BAUD_HZ)
`define RTDC_FRAME_BITS 4'ha

`endif

/* hdl/rtdc_pkg.sv */
// rtdc_pkg: shared types of the rs485 direction-control serial port
// assumes rtdc_consts.svh supplies the numbers
`default_nettype none

package rtdc_pkg;
   typedef logic [7:0] rtdc_byte_t;
   typedef logic [2:0] rtdc_addr_t;
   typedef enum logic [1:0] {RTDC_RX_IDLE, RTDC_RX_START, RTDC_RX_BITS, RTDC_RX_STOP} rtdc_rx_e;
endpackage : rtdc_pkg

`default_nettype wire

/* hdl/rtdc_tx_if.sv */
// rtdc_tx_if: load handshake between holding register and shifter
// assumes one clock domain
`default_nettype none

interface rtdc_tx_if;
   import rtdc_pkg::*;
   logic load;
   rtdc_byte_t data;
   logic busy;
   modport ctrl (output load, output data, input busy);
   modport shifter (input load, input data, output busy);
endinterface : rtdc_tx_if

`default_nettype wire

/* hdl/rtdc_tx_shift.sv */
// rtdc_tx_shift: serialises one 8n1 frame per load
// assumes load only while busy is low
`default_nettype none
`include "rtdc_consts.svh"

module rtdc_tx_shift #(
   parameter int CLKS_PER_BIT = `RTDC_CLKS_PER_BIT
) (
   input wire logic core_clk,
   input wire logic rst_sync_n,
   rtdc_tx_if.shifter tx,
   output logic serial_out
);
   import rtdc_pkg::*;

   logic [9:0] frame;
   logic [3:0] bits_left;
   logic [15:0] bit_cnt;

   // ------------------------------------------------------------------
   // frame shifter
   // ------------------------------------------------------------------
   // shifter busy state
   assign tx.busy = (bits_left != 4'h0);
   assign serial_out = frame[0];

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         frame <= 10'h3ff;
         bits_left <= 4'h0;
         bit_cnt <= 16'h0000;
      end else if (tx.load && !tx.busy) begin
         frame <= {1'b1, tx.data, 1'b0};
         bits_left <= `RTDC_FRAME_BITS;
         bit_cnt <= 16'(CLKS_PER_BIT - 1);
      end else if (tx.busy) begin
         if (bit_cnt == 16'h0000) begin
            frame <= {1'b1, frame[9:1]};
            bits_left <= bits_left - 4'h1;
            bit_cnt <= 16'(CLKS_PER_BIT - 1);
         end else begin
            bit_cnt <= bit_cnt - 16'h0001;
         end
      end
   end
endmodule : rtdc_tx_shift

`default_nettype wire

/* tb/rtdc_top_assertions.sv */
// rtdc_top_assertions: port checks of rtdc_top
// assumes bound to rtdc_top, one clock domain
`default_nettype none
`include "rtdc_consts.svh"

module rtdc_top_assertions #(
   parameter int CLKS_PER_BIT = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire rtdc_pkg::rtdc_addr_t io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire rtdc_pkg::rtdc_byte_t io_wdata,
   input wire rtdc_pkg::rtdc_byte_t io_rdata,
   input wire logic serial_out,
   input wire logic serial_in,
   input wire logic line_driver_enable,
   input wire logic dtr
);
   logic mcr_wr;
   logic lsr_rd;
   assign mcr_wr = io_wr && io_addr == `RTDC_OFS_MODEM_CTRL;
   assign lsr_rd = io_rd && io_addr == `RTDC_OFS_LINE_STATUS;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   drv_follow_a: assert property (mcr_wr |=> line_driver_enable == $past(io_wdata[0]))
      else $error("enable differs from written bit");
   drv_hold_a: assert property (!mcr_wr |=> $stable(line_driver_enable))
      else $error("enable moved without write");
   dtr_same_a: assert property (dtr == line_driver_enable)
      else $error("dtr differs from enable");
   reset_off_a: assert property ($rose(rst_n) |-> !line_driver_enable && serial_out)
      else $error("not idle after reset");
   hold_full_a: assert property (io_wr && io_addr == 3'h0 ##1 lsr_rd |=> io_rdata[5])
      else $error("holding bit clear after write");
   shift_busy_a: assert property (lsr_rd && !serial_out |=> io_rdata[6])
      else $error("shifter bit clear while sending");
   status_rsvd_a: assert property (lsr_rd |=> io_rdata[7] == 1'b0 && io_rdata[4:2] == 3'h0)
      else $error("unused status bits set");
   cover property (mcr_wr && io_wdata[0]);
   cover property (lsr_rd && !serial_out);
   cover property ($fell(line_driver_enable));
endmodule : rtdc_top_assertions

bind rtdc_top rtdc_top_assertions #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_rtdc_top_assertions (
   .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .serial_out(serial_out),
   .serial_in(serial_in), .line_driver_enable(line_driver_enable), .dtr(dtr));

`default_nettype wire

/* tb/rtdc_xcvr_model.sv */
// rtdc_xcvr_model: rs485 transceiver plus remote node on a biased bus
// assumes 8n1 frames of CLKS_PER_BIT core_clk cycles per bit
`default_nettype none

module rtdc_xcvr_model #(
   parameter int CLKS_PER_BIT = 8
) (
   input wire logic core_clk,
   input wire logic tx_line,
   input wire logic drv_en,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic remote = 1'b1;
   logic [7:0] cap;
   logic [7:0] got [$];
   assign rx_line = (drv_en === 1'b1) ? tx_line : remote;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         remote = f[i];
         repeat (CLKS_PER_BIT) @(posedge core_clk);
         #1;
      end
   endtask : send
   // captures frames driven onto the bus
   always begin
      @(negedge rx_line);
      if (drv_en === 1'b1) begin
         repeat (CLKS_PER_BIT / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (CLKS_PER_BIT) @(posedge core_clk);
            cap[i] = rx_line;
         end
         got.push_back(cap);
      end
   end
endmodule : rtdc_xcvr_model

`default_nettype wire

/* tb/rtdc_top_tb_top.sv */
// rtdc_top_tb_top: self-checking bench of rtdc_top
// assumes transceiver model on the line side
`default_nettype none

module rtdc_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rtdc_pkg::*;
   typedef struct {rtdc_addr_t a; rtdc_byte_t w; rtdc_byte_t r; logic en;} rtdc_row_s;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   rtdc_addr_t io_addr = 3'h0;
   rtdc_byte_t io_wdata = 8'h00;
   rtdc_byte_t io_rdata;
   rtdc_byte_t d;
   logic serial_out, serial_in, line_driver_enable, dtr;
   int num_errors = 0;
   int tests_run = 0;
   rtdc_row_s rows [6] = '{'{3'h4, 8'h01, 8'h01, 1'b1}, '{3'h4, 8'hfe, 8'hfe, 1'b0},
      '{3'h4, 8'hff, 8'hff, 1'b1}, '{3'h4, 8'h00, 8'h00, 1'b0},
      '{3'h7, 8'hff, 8'h00, 1'b0}, '{3'h5, 8'hff, 8'h00, 1'b0}};

   initial forever #5 core_clk = ~core_clk;

   rtdc_top #(.CLKS_PER_BIT(8)) u_rtdc_top (.core_clk(core_clk), .rst_n(rst_n),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .serial_out(serial_out), .serial_in(serial_in),
      .line_driver_enable(line_driver_enable), .dtr(dtr));
   rtdc_xcvr_model #(.CLKS_PER_BIT(8)) u_rtdc_xcvr_model (.core_clk(core_clk),
      .tx_line(serial_out), .drv_en(line_driver_enable), .rx_line(serial_in));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input rtdc_byte_t seen, input rtdc_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic acc(input logic w, input logic r, input rtdc_addr_t a, input rtdc_byte_t wd);
      io_wr = w;
      io_rd = r;
      io_addr = a;
      io_wdata = wd;
      @(posedge core_clk);
      #1;
      d = io_rdata;
   endtask : acc
   task automatic idle;
      io_wr = 1'b0;
      io_rd = 1'b0;
      @(posedge core_clk);
      #1;
   endtask : idle
   task automatic poll(input rtdc_byte_t m, input rtdc_byte_t want);
      int n;
      n = 0;
      do begin
         acc(1'b0, 1'b1, 3'h5, 8'h00);
         n++;
      end while ((d & m) !== want && n < 400);
      idle;
      chk(d & m, want);
      if ((d & m) !== want) close_out;
   endtask : poll

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk({7'h0, line_driver_enable}, 8'h00);
      chk({7'h0, serial_out}, 8'h01);
      $display("reset check done");
      acc(1'b0, 1'b1, 3'h4, 8'h00);
      acc(1'b1, 1'b0, 3'h4, d & 8'hfa);
      idle;
      foreach (rows[i]) begin
         acc(1'b1, 1'b0, rows[i].a, rows[i].w);
         acc(1'b0, 1'b1, rows[i].a, 8'h00);
         idle;
         chk(d, rows[i].r);
         chk({7'h0, line_driver_enable}, {7'h0, rows[i].en});
         chk({7'h0, dtr}, {7'h0, rows[i].en});
      end
      $display("register table done");
      acc(1'b0, 1'b1, 3'h4, 8'h00);
      acc(1'b1, 1'b0, 3'h4, d | 8'h01);
      acc(1'b1, 1'b0, 3'h0, 8'h3c);
      acc(1'b0, 1'b1, 3'h5, 8'h00);
      chk(d & 8'h20, 8'h20);
      acc(1'b1, 1'b0, 3'h0, 8'ha5);
      acc(1'b0, 1'b1, 3'h5, 8'h00);
      idle;
      chk(d & 8'h60, 8'h60);
      poll(8'h60, 8'h00);
      chk({7'h0, line_driver_enable}, 8'h01);
      acc(1'b0, 1'b1, 3'h4, 8'h00);
      acc(1'b1, 1'b0, 3'h4, d & 8'hfa);
      idle;
      chk({7'h0, line_driver_enable}, 8'h00);
      chk(8'(u_rtdc_xcvr_model.got.size()), 8'h02);
      chk(u_rtdc_xcvr_model.got[0], 8'h3c);
      chk(u_rtdc_xcvr_model.got[1], 8'ha5);
      $display("block transmit done");
      acc(1'b0, 1'b1, 3'h0, 8'h00);
      acc(1'b0, 1'b1, 3'h5, 8'h00);
      idle;
      u_rtdc_xcvr_model.send(8'h5a);
      poll(8'h01, 8'h01);
      acc(1'b0, 1'b1, 3'h0, 8'h00);
      idle;
      chk(d, 8'h5a);
      $display("receive done");
      acc(1'b1, 1'b0, 3'h4, 8'h01);
      idle;
      rst_n = 1'b0;
      #1;
      chk({7'h0, line_driver_enable}, 8'h00);
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      acc(1'b0, 1'b1, 3'h4, 8'h00);
      idle;
      chk(d, 8'h00);
      $display("mid-run reset done");
      close_out;
   end
endmodule : rtdc_top_tb_top

`default_nettype wire
